// File: rxpls_map.vh
// Register offsets, field positions, reset values and timing counts of the receive-port status block
// How it works
// RQ1: Report line count of latest frame, two bytes
// RQ2: Freeze line count until read when enabled
// RQ3: High-byte read latches low byte, high first
// RQ4: Report line length, last line of frame
// RQ5: Freeze line length until read when enabled
// RQ6: High-byte read latches length low byte
// RQ7: Replace frequency only beyond hysteresis MHz band
// RQ8: Declare clock stable after selected stable time
// RQ9: Flag no clock below low threshold MHz
// RQ10: Eight-bit mailbox byte, stores writes only
// RQ11: Port select chooses which port copy accessed
// RQ12: Unfreeze after high then low byte read
`ifndef RXPLS_MAP_VH
`define RXPLS_MAP_VH

// Register offsets
`define RXPLS_PORT_SEL_ADDR     8'h4c
`define RXPLS_LT_HIGH_ADDR      8'h73
`define RXPLS_LT_LOW_ADDR       8'h74
`define RXPLS_LL_HIGH_ADDR      8'h75
`define RXPLS_LL_LOW_ADDR       8'h76
`define RXPLS_FDET_CTL_ADDR     8'h77
`define RXPLS_MBOX0_ADDR        8'h78

// Reset values
`define RXPLS_LINE_RST          16'h0000
`define RXPLS_FDET_CTL_RST      8'hc5
`define RXPLS_MBOX0_RST         8'h00
`define RXPLS_RDATA_RST         8'h00

// Frequency detect control field positions
`define RXPLS_HYST_MSB          7
`define RXPLS_HYST_LSB          6
`define RXPLS_STABLE_MSB        5
`define RXPLS_STABLE_LSB        4
`define RXPLS_LOW_THR_MSB       3
`define RXPLS_LOW_THR_LSB       0

// Stable times of 40us, 80us, 320us, 1.28ms in 100 ns cycles
`define RXPLS_STABLE_T0_CYC     400
`define RXPLS_STABLE_T1_CYC     800
`define RXPLS_STABLE_T2_CYC     3200
`define RXPLS_STABLE_T3_CYC     12800

`endif

// File: rxpls_freq.v
// Receive clock frequency detector for one port: hysteresis, stability timer, low-frequency flag
`timescale 1ns/100ps
`default_nettype none
`include "rxpls_map.vh"

module rxpls_freq #(
    parameter integer CNT_W  = 14, // Width of the stability timer
    parameter integer T0_CYC = `RXPLS_STABLE_T0_CYC,     // Stable time, selection 00
    parameter integer T1_CYC = `RXPLS_STABLE_T1_CYC,     // Stable time, selection 01
    parameter integer T2_CYC = `RXPLS_STABLE_T2_CYC,     // Stable time, selection 10
    parameter integer T3_CYC = `RXPLS_STABLE_T3_CYC      // Stable time, selection 11
) (
    input  wire       core_clk_i,       // System clock
    input  wire       rstn_i,           // Synchronous reset, active low
    input  wire       meas_valid_i,     // New measurement present this cycle
    input  wire [7:0] meas_mhz_i,       // Measured frequency in MHz
    input  wire [1:0] hyst_i,           // Hysteresis in MHz
    input  wire [1:0] stable_sel_i,     // Stable time selection
    input  wire [3:0] low_thr_i,        // Low threshold in MHz
    output reg  [7:0] freq_mhz_o,       // Stored frequency
    output reg        stable_o,         // Clock declared stable
    output reg        no_clock_o        // Clock below low threshold
);

    reg  [CNT_W-1:0] cnt_q;             // Cycles since last stored change
    reg  [CNT_W-1:0] limit;             // Selected stable time in cycles
    wire [7:0]       diff;              // Distance of measurement from stored value
    wire             change;            // Measurement leaves the hysteresis band

    // Absolute difference between new and stored frequency
    assign diff   = (meas_mhz_i > freq_mhz_o) ? (meas_mhz_i - freq_mhz_o) : (freq_mhz_o - meas_mhz_i);
    assign change = meas_valid_i && (diff > {6'h00, hyst_i}); // RQ7

    // Stable time lookup
    always @* begin
        case (stable_sel_i)
            2'b00:   limit = T0_CYC[CNT_W-1:0];
            2'b01:   limit = T1_CYC[CNT_W-1:0];
            2'b10:   limit = T2_CYC[CNT_W-1:0];
            default: limit = T3_CYC[CNT_W-1:0];
        endcase
    end

    // Stored frequency replaced only outside the band
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            freq_mhz_o <= 8'h00;
        end else if (change) begin
            freq_mhz_o <= meas_mhz_i; // RQ7
        end
    end

    // Stability timer restarts on every change and saturates at the limit
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            cnt_q    <= {CNT_W{1'b0}};
            stable_o <= 1'b0;
        end else begin
            if (change) begin
                cnt_q <= {CNT_W{1'b0}};
            end else if (cnt_q < limit) begin
                cnt_q <= cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
            end
            stable_o <= !change && (cnt_q >= limit); // RQ8
        end
    end

    // No-clock flag follows each measurement against the low threshold
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            no_clock_o <= 1'b0;
        end else if (meas_valid_i) begin
            no_clock_o <= (meas_mhz_i < {4'h0, low_thr_i}); // RQ9
        end
    end

endmodule // rxpls_freq
`default_nettype wire

// File: rxpls_top.v
// Per-receive-port line statistics, frequency detector and mailbox register bank
`timescale 1ns/100ps
`default_nettype none
`include "rxpls_map.vh"

module rxpls_top #(
    parameter integer NUM_PORTS = 4,                     // Receive ports
    parameter integer SEL_W     = 2,                     // Port select width
    parameter integer LINE_W    = 16,                    // Line count and length width
    parameter integer CNT_W     = 14,                    // Stability timer width
    parameter integer T0_CYC    = `RXPLS_STABLE_T0_CYC,  // Stable time, selection 00
    parameter integer T1_CYC    = `RXPLS_STABLE_T1_CYC,  // Stable time, selection 01
    parameter integer T2_CYC    = `RXPLS_STABLE_T2_CYC,  // Stable time, selection 10
    parameter integer T3_CYC    = `RXPLS_STABLE_T3_CYC   // Stable time, selection 11
) (
    input  wire                        core_clk_i,      // System clock
    input  wire                        rstn_i,          // Synchronous reset, active low
    input  wire [SEL_W-1:0]            port_sel_i,      // Port chosen by the select register
    input  wire                        reg_wr_i,        // Register write strobe
    input  wire                        reg_rd_i,        // Register read strobe
    input  wire [7:0]                  reg_addr_i,      // Register offset
    input  wire [7:0]                  reg_wdata_i,     // Write data
    output reg  [7:0]                  reg_rdata_o,     // Read data, one cycle after the strobe
    input  wire [NUM_PORTS-1:0]        line_end_i,      // End of a video line, per port
    input  wire [NUM_PORTS*LINE_W-1:0] line_len_i,      // Length of the line ending now
    input  wire [NUM_PORTS-1:0]        frame_end_i,     // End of a video frame, per port
    input  wire [NUM_PORTS-1:0]        line_total_change_irq_enable_i,  // Freeze line count
    input  wire [NUM_PORTS-1:0]        line_length_change_irq_enable_i, // Freeze line length
    input  wire [NUM_PORTS-1:0]        freq_valid_i,    // New frequency measurement
    input  wire [NUM_PORTS*8-1:0]      freq_mhz_i,      // Measured frequency in MHz
    output wire [NUM_PORTS*8-1:0]      freq_mhz_o,      // Stored frequency per port
    output wire [NUM_PORTS-1:0]        clock_stable_o,  // Stable clock per port
    output wire [NUM_PORTS-1:0]        no_receive_clock_o // No receive clock per port
);

    // Flattened per-port state for the read multiplexer
    wire [NUM_PORTS*LINE_W-1:0] lt_rep_w;      // Reported line counts
    wire [NUM_PORTS*8-1:0]      lt_hold_w;     // Latched line count low bytes
    wire [NUM_PORTS-1:0]        lt_seen_w;     // Line count high byte read, low pending
    wire [NUM_PORTS*LINE_W-1:0] ll_rep_w;      // Reported line lengths
    wire [NUM_PORTS*8-1:0]      ll_hold_w;     // Latched line length low bytes
    wire [NUM_PORTS-1:0]        ll_seen_w;     // Line length high byte read, low pending
    wire [NUM_PORTS*8-1:0]      ctl_w;         // Frequency detect control bytes
    wire [NUM_PORTS*8-1:0]      mbox_w;        // Mailbox bytes

    // Address decode shared by all ports
    wire rd_lt_hi = reg_rd_i && (reg_addr_i == `RXPLS_LT_HIGH_ADDR);
    wire rd_lt_lo = reg_rd_i && (reg_addr_i == `RXPLS_LT_LOW_ADDR);
    wire rd_ll_hi = reg_rd_i && (reg_addr_i == `RXPLS_LL_HIGH_ADDR);
    wire rd_ll_lo = reg_rd_i && (reg_addr_i == `RXPLS_LL_LOW_ADDR);
    wire wr_ctl   = reg_wr_i && (reg_addr_i == `RXPLS_FDET_CTL_ADDR);
    wire wr_mbox  = reg_wr_i && (reg_addr_i == `RXPLS_MBOX0_ADDR);

    genvar p;
    generate
        for (p = 0; p < NUM_PORTS; p = p + 1) begin : g_port
            wire              sel_p;           // This port is the selected copy
            wire              frame_p;         // Frame end on this port
            wire              line_p;          // Line end on this port
            wire [LINE_W-1:0] lt_fin;          // Line count of the frame now ending
            wire [LINE_W-1:0] ll_fin;          // Last line length of the frame now ending
            reg  [LINE_W-1:0] lt_run_q;        // Lines seen so far in this frame
            reg  [LINE_W-1:0] ll_last_q;       // Length of the latest completed line
            reg  [LINE_W-1:0] lt_rep_q;        // Reported line count
            reg  [LINE_W-1:0] ll_rep_q;        // Reported line length
            reg               lt_frz_q;        // Line count frozen until read
            reg               ll_frz_q;        // Line length frozen until read
            reg               lt_seen_q;       // Line count high byte read
            reg               ll_seen_q;       // Line length high byte read
            reg  [7:0]        lt_hold_q;       // Line count low byte latch
            reg  [7:0]        ll_hold_q;       // Line length low byte latch
            reg  [7:0]        ctl_q;           // Frequency detect control
            reg  [7:0]        mbox_q;          // Mailbox byte

            localparam [SEL_W-1:0] PORT_ID = p; // Select value of this port
            assign sel_p   = (port_sel_i == PORT_ID); // RQ11
            assign frame_p = frame_end_i[p];
            assign line_p  = line_end_i[p];
            // A line ending in the frame-end cycle still belongs to that frame
            assign lt_fin  = lt_run_q + {{(LINE_W-1){1'b0}}, line_p};
            assign ll_fin  = line_p ? line_len_i[p*LINE_W +: LINE_W] : ll_last_q; // RQ4

            // Running line counter, restarted at each frame end
            always @(posedge core_clk_i) begin
                if (!rstn_i) begin
                    lt_run_q <= `RXPLS_LINE_RST;
                end else if (frame_p) begin
                    lt_run_q <= `RXPLS_LINE_RST;
                end else if (line_p) begin
                    lt_run_q <= lt_fin;
                end
            end

            // Length of the most recent line
            always @(posedge core_clk_i) begin
                if (!rstn_i) begin
                    ll_last_q <= `RXPLS_LINE_RST;
                end else if (line_p) begin
                    ll_last_q <= line_len_i[p*LINE_W +: LINE_W];
                end
            end

            // Line count report and its freeze
            always @(posedge core_clk_i) begin
                if (!rstn_i) begin
                    lt_rep_q <= `RXPLS_LINE_RST;
                    lt_frz_q <= 1'b0;
                end else begin
                    if (frame_p && !lt_frz_q) begin
                        lt_rep_q <= lt_fin; // RQ1
                    end
                    // New values blocked while frozen
                    if (frame_p && !lt_frz_q && line_total_change_irq_enable_i[p]) begin
                        lt_frz_q <= 1'b1; // RQ2
                    end else if (sel_p && rd_lt_lo && lt_seen_q) begin
                        lt_frz_q <= 1'b0; // RQ12
                    end
                end
            end

            // Line length report and its freeze
            always @(posedge core_clk_i) begin
                if (!rstn_i) begin
                    ll_rep_q <= `RXPLS_LINE_RST;
                    ll_frz_q <= 1'b0;
                end else begin
                    if (frame_p && !ll_frz_q) begin
                        ll_rep_q <= ll_fin; // RQ4
                    end
                    if (frame_p && !ll_frz_q && line_length_change_irq_enable_i[p]) begin
                        ll_frz_q <= 1'b1; // RQ5
                    end else if (sel_p && rd_ll_lo && ll_seen_q) begin
                        ll_frz_q <= 1'b0; // RQ12
                    end
                end
            end

            // Low byte latches taken on high byte reads
            always @(posedge core_clk_i) begin
                if (!rstn_i) begin
                    lt_seen_q <= 1'b0;
                    lt_hold_q <= 8'h00;
                    ll_seen_q <= 1'b0;
                    ll_hold_q <= 8'h00;
                end else begin
                    if (sel_p && rd_lt_hi) begin
                        lt_seen_q <= 1'b1; // RQ3
                        lt_hold_q <= lt_rep_q[7:0]; // RQ3
                    end else if (sel_p && rd_lt_lo) begin
                        lt_seen_q <= 1'b0;
                    end
                    if (sel_p && rd_ll_hi) begin
                        ll_seen_q <= 1'b1; // RQ6
                        ll_hold_q <= ll_rep_q[7:0]; // RQ6
                    end else if (sel_p && rd_ll_lo) begin
                        ll_seen_q <= 1'b0;
                    end
                end
            end

            // Writable bytes of the selected port
            always @(posedge core_clk_i) begin
                if (!rstn_i) begin
                    ctl_q  <= `RXPLS_FDET_CTL_RST;
                    mbox_q <= `RXPLS_MBOX0_RST;
                end else begin
                    if (sel_p && wr_ctl) begin
                        ctl_q <= reg_wdata_i; // RQ11
                    end
                    if (sel_p && wr_mbox) begin
                        mbox_q <= reg_wdata_i; // RQ10
                    end
                end
            end

            // Frequency detector driven by this port's control byte
            rxpls_freq #(
                .CNT_W  (CNT_W),
                .T0_CYC (T0_CYC),
                .T1_CYC (T1_CYC),
                .T2_CYC (T2_CYC),
                .T3_CYC (T3_CYC)
            ) u_freq (
                .core_clk_i   (core_clk_i),
                .rstn_i       (rstn_i),
                .meas_valid_i (freq_valid_i[p]),
                .meas_mhz_i   (freq_mhz_i[p*8 +: 8]),
                .hyst_i       (ctl_q[`RXPLS_HYST_MSB:`RXPLS_HYST_LSB]),
                .stable_sel_i (ctl_q[`RXPLS_STABLE_MSB:`RXPLS_STABLE_LSB]),
                .low_thr_i    (ctl_q[`RXPLS_LOW_THR_MSB:`RXPLS_LOW_THR_LSB]),
                .freq_mhz_o   (freq_mhz_o[p*8 +: 8]),
                .stable_o     (clock_stable_o[p]),
                .no_clock_o   (no_receive_clock_o[p])
            );

            // Flatten for the read path
            assign lt_rep_w[p*LINE_W +: LINE_W] = lt_rep_q;
            assign ll_rep_w[p*LINE_W +: LINE_W] = ll_rep_q;
            assign lt_hold_w[p*8 +: 8]          = lt_hold_q;
            assign ll_hold_w[p*8 +: 8]          = ll_hold_q;
            assign lt_seen_w[p]                 = lt_seen_q;
            assign ll_seen_w[p]                 = ll_seen_q;
            assign ctl_w[p*8 +: 8]              = ctl_q;
            assign mbox_w[p*8 +: 8]             = mbox_q;
        end
    endgenerate

    // Read multiplexer over the selected port's copy
    reg [7:0] rd_mux;                          // Byte for the current read
    always @* begin
        rd_mux = 8'h00;
        case (reg_addr_i)
            `RXPLS_LT_HIGH_ADDR: begin
                rd_mux = lt_rep_w[port_sel_i*LINE_W + 8 +: 8];
            end
            `RXPLS_LT_LOW_ADDR: begin
                // Latched byte after a high read keeps the pair coherent
                rd_mux = lt_seen_w[port_sel_i] ? lt_hold_w[port_sel_i*8 +: 8]
                                               : lt_rep_w[port_sel_i*LINE_W +: 8];     // RQ3
            end
            `RXPLS_LL_HIGH_ADDR: begin
                rd_mux = ll_rep_w[port_sel_i*LINE_W + 8 +: 8];
            end
            `RXPLS_LL_LOW_ADDR: begin
                rd_mux = ll_seen_w[port_sel_i] ? ll_hold_w[port_sel_i*8 +: 8]
                                               : ll_rep_w[port_sel_i*LINE_W +: 8];     // RQ6
            end
            `RXPLS_FDET_CTL_ADDR: begin
                rd_mux = ctl_w[port_sel_i*8 +: 8];
            end
            `RXPLS_MBOX0_ADDR: begin
                rd_mux = mbox_w[port_sel_i*8 +: 8]; // RQ10
            end
            default: begin
                rd_mux = 8'h00;
            end
        endcase
    end

    // Registered read data, held until the next read
    always @(posedge core_clk_i) begin
        if (!rstn_i) begin
            reg_rdata_o <= `RXPLS_RDATA_RST;
        end else if (reg_rd_i) begin
            reg_rdata_o <= rd_mux; // RQ11
        end
    end

endmodule // rxpls_top
`default_nettype wire

// File: rxpls_properties.sv
// Concurrent checks on the ports of the receive-port status block
`timescale 1ns/100ps
`default_nettype none
module rxpls_properties #(
    parameter integer NUM_PORTS = 4,  // Receive ports
    parameter integer SEL_W     = 2   // Port select width
) (
    input wire logic [0:0]             core_clk_i,         // System clock
    input wire logic [0:0]             rstn_i,             // Reset, active low
    input wire logic [SEL_W-1:0]       port_sel_i,         // Port select
    input wire logic [0:0]             reg_wr_i,           // Write strobe
    input wire logic [0:0]             reg_rd_i,           // Read strobe
    input wire logic [7:0]             reg_addr_i,         // Register offset
    input wire logic [7:0]             reg_wdata_i,        // Write data
    input wire logic [7:0]             reg_rdata_o,        // Read data
    input wire logic [NUM_PORTS-1:0]   freq_valid_i,       // Measurement strobes
    input wire logic [NUM_PORTS*8-1:0] freq_mhz_i,         // Measurements
    input wire logic [NUM_PORTS*8-1:0] freq_mhz_o,         // Stored frequencies
    input wire logic [NUM_PORTS-1:0]   clock_stable_o,     // Stable flags
    input wire logic [NUM_PORTS-1:0]   no_receive_clock_o  // Missing clock flags
);
    wire [7:0] meas0 = freq_mhz_i[7:0]; // Port 0 measurement
    wire [7:0] st0   = freq_mhz_o[7:0]; // Port 0 stored value
    wire [7:0] dif0  = (meas0 > st0) ? meas0 - st0 : st0 - meas0; // Distance from stored value
    default clocking cb @(posedge core_clk_i); endclocking
    default disable iff (!rstn_i);
    chk_rdata_reset_zero: assert property (disable iff (1'b0) !rstn_i |=> reg_rdata_o == 8'h00)
        else $error("read data not cleared by reset");
    chk_rdata_holds_idle: assert property (!reg_rd_i |=> $stable(reg_rdata_o))
        else $error("read data moved without a read");
    chk_unmapped_read_zero: assert property (reg_rd_i && reg_addr_i == 8'h00 |=> reg_rdata_o == 8'h00)
        else $error("unmapped offset read not zero");
    chk_mailbox_echo_back: assert property (reg_wr_i && reg_addr_i == 8'h78 ##1 !reg_wr_i ##1
        reg_rd_i && reg_addr_i == 8'h78 && $past(port_sel_i, 2) == port_sel_i
        |=> reg_rdata_o == $past(reg_wdata_i, 3))
        else $error("mailbox did not return written byte");
    chk_freq_big_update: assert property (freq_valid_i[0] && dif0 > 8'h03 |=> st0 == $past(meas0))
        else $error("frequency outside band not stored");
    chk_freq_same_kept: assert property (freq_valid_i[0] && dif0 == 8'h00 |=> $stable(st0))
        else $error("equal measurement stored");
    chk_freq_idle_kept: assert property (!freq_valid_i[0] |=> $stable(st0))
        else $error("stored frequency moved without measurement");
    chk_clock_present_flag: assert property (freq_valid_i[0] && meas0 > 8'h0f |=> !no_receive_clock_o[0])
        else $error("no-clock flag above threshold");
    chk_stable_drops_change: assert property (freq_valid_i[0] && dif0 > 8'h03 |=> !clock_stable_o[0] [*3])
        else $error("stable kept after change");
endmodule // rxpls_properties
bind rxpls_top rxpls_properties #(.NUM_PORTS(NUM_PORTS), .SEL_W(SEL_W)) u_props (.core_clk_i(core_clk_i),
    .rstn_i(rstn_i), .port_sel_i(port_sel_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o), .freq_valid_i(freq_valid_i), .freq_mhz_i(freq_mhz_i),
    .freq_mhz_o(freq_mhz_o), .clock_stable_o(clock_stable_o), .no_receive_clock_o(no_receive_clock_o));
`default_nettype wire

// File: rxpls_host.sv
// Register host model: port select and one-cycle read and write strobes
`timescale 1ns/100ps
`default_nettype none
module rxpls_host (
    input  wire logic       core_clk_i,   // System clock
    input  wire logic [7:0] reg_rdata_i,  // Read data from the block
    output var logic [1:0]  port_sel_o,   // Port select value
    output var logic        reg_wr_o,     // Write strobe
    output var logic        reg_rd_o,     // Read strobe
    output var logic [7:0]  reg_addr_o,   // Register offset
    output var logic [7:0]  reg_wdata_o   // Write data
);
    // Idle bus from time zero
    initial begin
        port_sel_o = 2'h0;
        reg_wr_o = 1'b0;
        reg_rd_o = 1'b0;
        reg_addr_o = 8'hff;
        reg_wdata_o = 8'h5a;
    end
    // Select the port copy before touching its registers
    task sel(input logic [1:0] p);
        @(negedge core_clk_i);
        port_sel_o = p;
    endtask
    // Write strobe for one cycle; released lines show inverted values
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge core_clk_i);
        reg_addr_o = a;
        reg_wdata_o = d;
        reg_wr_o = 1'b1;
        @(negedge core_clk_i);
        reg_wr_o = 1'b0;
        reg_addr_o = ~a;
        reg_wdata_o = ~d;
    endtask
    // Read strobe for one cycle; data is taken one cycle later
    task rd(input logic [7:0] a, output logic [7:0] d);
        @(negedge core_clk_i);
        reg_addr_o = a;
        reg_rd_o = 1'b1;
        @(negedge core_clk_i);
        reg_rd_o = 1'b0;
        reg_addr_o = ~a;
        d = reg_rdata_i;
    endtask
endmodule // rxpls_host
`default_nettype wire

// File: tb_top.sv
// Self-checking testbench of the receive-port status block
`timescale 1ns/100ps
`default_nettype none
module tb_top;
    logic        core_clk, rst_n;                      // Clock and reset
    logic [1:0]  port_sel;                             // Port select from host
    logic        reg_wr, reg_rd;                       // Strobes from host
    logic [7:0]  reg_addr, reg_wdata, reg_rdata;       // Register bus
    logic [3:0]  line_end, frame_end, lt_frz, ll_frz;  // Video events and freeze enables
    logic [3:0]  freq_valid, stable, no_clk;           // Frequency strobes and flags
    logic [63:0] line_len;                             // Line lengths
    logic [31:0] freq_in, freq_out;                    // Measured and stored frequency
    int          n_fail, check_count;                  // Counters
    rxpls_top #(.T0_CYC(4), .T1_CYC(8), .T2_CYC(16), .T3_CYC(32)) dut (.core_clk_i(core_clk), .rstn_i(rst_n),
        .port_sel_i(port_sel), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_rdata_o(reg_rdata), .line_end_i(line_end), .line_len_i(line_len), .frame_end_i(frame_end),
        .line_total_change_irq_enable_i(lt_frz), .line_length_change_irq_enable_i(ll_frz),
        .freq_valid_i(freq_valid), .freq_mhz_i(freq_in), .freq_mhz_o(freq_out), .clock_stable_o(stable),
        .no_receive_clock_o(no_clk));
    rxpls_host host (.core_clk_i(core_clk), .reg_rdata_i(reg_rdata), .port_sel_o(port_sel), .reg_wr_o(reg_wr),
        .reg_rd_o(reg_rd), .reg_addr_o(reg_addr), .reg_wdata_o(reg_wdata));
    // Free-running 10 MHz clock
    initial begin
        core_clk = 1'b0;
        forever #50 core_clk = ~core_clk;
    end
    // Compare and count
    task check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Read a register and compare
    task rdc(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        host.rd(a, d);
        check(d, exp);
    endtask
    // One line end, optionally closing the frame
    task line(input int p, input logic [15:0] len, input logic fe);
        @(negedge core_clk);
        line_end[p] = 1'b1;
        line_len[p*16 +: 16] = len;
        frame_end[p] = fe;
        @(negedge core_clk);
        line_end[p] = 1'b0;
        frame_end[p] = 1'b0;
        line_len[p*16 +: 16] = ~len;
    endtask
    // A frame of n lines whose last line has the given length
    task frame(input int p, input int n, input logic [15:0] last);
        for (int i = 1; i < n; i++) line(p, 16'h0011 + 16'(i), 1'b0);
        line(p, last, 1'b1);
    endtask
    // One frequency measurement on port p
    task meas(input int p, input logic [7:0] v);
        @(negedge core_clk);
        freq_valid[p] = 1'b1;
        freq_in[p*8 +: 8] = v;
        @(negedge core_clk);
        freq_valid[p] = 1'b0;
    endtask
    // Reset values on every port, unmapped offset reads zero
    task t_reset_values();
        for (int p = 0; p < 4; p++) begin
            host.sel(2'(p));
            rdc(8'h77, 8'hc5);
            rdc(8'h78, 8'h00);
            rdc(8'h74, 8'h00);
            rdc(8'h76, 8'h00);
            rdc(8'h00, 8'h00);
        end
    endtask
    // Separate mailbox per port; read-only offset ignores writes
    task t_mailbox();
        for (int p = 0; p < 4; p++) begin
            host.sel(2'(p));
            host.wr(8'h78, 8'h30 + 8'(p));
            host.wr(8'h74, 8'hff);
            rdc(8'h78, 8'h30 + 8'(p));
        end
        for (int p = 0; p < 4; p++) begin
            host.sel(2'(p));
            rdc(8'h78, 8'h30 + 8'(p));
            rdc(8'h74, 8'h00);
        end
    endtask
    // Line count and length with latched low bytes across a new frame
    task t_line_pair();
        host.sel(2'h1);
        frame(1, 258, 16'h0789);
        rdc(8'h73, 8'h01);
        frame(1, 5, 16'h0abc);
        rdc(8'h74, 8'h02);
        rdc(8'h75, 8'h0a);
        frame(1, 2, 16'h0def);
        rdc(8'h76, 8'hbc);
        rdc(8'h73, 8'h00);
        rdc(8'h74, 8'h02);
    endtask
    // Frozen reports ignore frames until both bytes are read
    task t_freeze();
        lt_frz[1] = 1'b1;
        ll_frz[1] = 1'b1;
        frame(1, 7, 16'h0123);
        frame(1, 9, 16'h0456);
        rdc(8'h73, 8'h00);
        rdc(8'h74, 8'h07);
        rdc(8'h75, 8'h01);
        rdc(8'h76, 8'h23);
        frame(1, 4, 16'h0321);
        rdc(8'h73, 8'h00);
        rdc(8'h74, 8'h04);
        rdc(8'h75, 8'h03);
        rdc(8'h76, 8'h21);
    endtask
    // Hysteresis band, stable time per selection, low threshold
    task t_freq();
        int k;
        host.sel(2'h0);
        host.wr(8'h77, 8'h85);
        meas(0, 8'd50);
        check(freq_out[7:0], 8'd50);
        meas(0, 8'd52);
        check(freq_out[7:0], 8'd50);
        meas(0, 8'd53);
        check(freq_out[7:0], 8'd53);
        for (int s = 0; s < 4; s++) begin
            host.wr(8'h77, {2'h2, 2'(s), 4'h5});
            meas(0, 8'd60 + 8'(s * 20));
            repeat (2) @(negedge core_clk);
            for (k = 2; k < 40; k++) begin
                if (stable[0] === 1'b1) break;
                @(negedge core_clk);
            end
            check({7'h00, k >= (4 << s) && k <= (4 << s) + 2}, 8'h01);
            if (k >= 40) finish_test();
        end
        meas(2, 8'd4);
        check({7'h00, no_clk[2]}, 8'h01);
        meas(2, 8'd5);
        check({7'h00, no_clk[2]}, 8'h00);
        host.wr(8'h77, 8'h89);
        meas(0, 8'd8);
        check({7'h00, no_clk[0]}, 8'h01);
    endtask
    // Counts, verdict and end of run
    task finish_test();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    // Main sequence
    initial begin
        n_fail = 0;
        check_count = 0;
        rst_n = 1'b0;
        {line_end, frame_end, lt_frz, ll_frz, freq_valid} = 20'h00000;
        line_len = 64'h0;
        freq_in = 32'h0;
        repeat (12) @(negedge core_clk);
        rst_n = 1'b1;
        t_reset_values();
        t_mailbox();
        t_line_pair();
        t_freeze();
        t_freq();
        finish_test();
    end
endmodule // tb_top
`default_nettype wire
